// *** rtl/fan_pwm_floor_ramp.sv ***
// Floor-select and ramp-rate configuration for three fan drive outputs.
// Assumes duty values and comparisons come from the fan control loop,
// synchronous to clk_in, and a one-cycle slot tick for ramping.
//
// Overview of operation
// - Auto mode, channel one below threshold: floor bit 5 picks 0% or min.
// - Auto mode, channel two below threshold: floor bit 6 picks 0% or min.
// - Auto mode, channel three below threshold: floor bit 7 picks off or min.
// - Once the lock bit is set, writes to the floor register are ignored.
// - Ramp register sits at 0x63 and resets to all zeros.
// - Three-bit ramp field makes channel three slew toward each new duty.
// - Ramp codes 0..7 step by 1, 2, 3, 5, 8, 12, 24, 48 per slot.
// - Channel three ramps only while its ramp enable bit 3 is set.
`timescale 1ns/1ps
`include "fan_ramp_cfg.svh"

module fan_pwm_floor_ramp (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Register port
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       wr_en_in,
   input  wire logic       rd_en_in,
   output logic      [7:0] rd_data_out,
   // Control loop inputs, one bit per channel, and a shared slot tick
   input  wire logic [2:0] auto_mode_in,
   input  wire logic [2:0] below_thresh_in,
   input  wire logic       slot_tick_in,
   // Minimum duty per channel
   input  wire logic [7:0] min_duty_one_in,
   input  wire logic [7:0] min_duty_two_in,
   input  wire logic [7:0] min_duty_three_in,
   // Newly calculated duty per channel
   input  wire logic [7:0] calc_duty_one_in,
   input  wire logic [7:0] calc_duty_two_in,
   input  wire logic [7:0] calc_duty_three_in,
   // Fan drive duty outputs
   output logic      [7:0] fan_drive_one_out,
   output logic      [7:0] fan_drive_two_out,
   output logic      [7:0] fan_drive_three_out
);

   fan_ramp_pkg::ctrl_s state_r;
   fan_ramp_pkg::ctrl_s state_nxt;

   logic       floor_select_ch1;
   logic       floor_select_ch2;
   logic       floor_select_ch3;
   logic [2:0] ramp_rate_ch3;
   logic       ramp_enable_ch3;
   logic [7:0] target_three;

   assign floor_select_ch1 = state_r.floor_cfg_r[`FLOOR_CH1_BIT];
   assign floor_select_ch2 = state_r.floor_cfg_r[`FLOOR_CH2_BIT];
   assign floor_select_ch3 = state_r.floor_cfg_r[`FLOOR_CH3_BIT];
   assign ramp_rate_ch3    =
      state_r.ramp_cfg_r[`RATE_CH3_MSB:`RATE_CH3_LSB];
   assign ramp_enable_ch3  = state_r.ramp_cfg_r[`RAMP_EN_CH3_BIT];

   // Channel three target before slewing
   assign target_three = fan_ramp_pkg::floor_duty(auto_mode_in[2],
                            below_thresh_in[2], floor_select_ch3,
                            min_duty_three_in, calc_duty_three_in);

   always_comb begin
      state_nxt = state_r;
      state_nxt.rd_data_r = 8'h00;

      // Lock is sticky until reset so software cannot undo it
      if (wr_en_in) begin
         if (addr_in == `FLOOR_CFG_ADDR) begin
            if (!state_r.lock_r) begin
               state_nxt.floor_cfg_r = wr_data_in;
            end
         end else if (addr_in == `RAMP_CFG_ADDR) begin
            if (!state_r.lock_r) begin
               state_nxt.ramp_cfg_r = wr_data_in;
            end
         end else if (addr_in == `LOCK_CFG_ADDR) begin
            if (wr_data_in[`LOCK_BIT]) begin
               state_nxt.lock_r = 1'b1;
            end
         end
      end

      // Unmapped reads return zero
      if (rd_en_in) begin
         if (addr_in == `FLOOR_CFG_ADDR) begin
            state_nxt.rd_data_r = state_r.floor_cfg_r;
         end else if (addr_in == `RAMP_CFG_ADDR) begin
            state_nxt.rd_data_r = state_r.ramp_cfg_r;
         end else if (addr_in == `LOCK_CFG_ADDR) begin
            state_nxt.rd_data_r = {7'h00, state_r.lock_r};
         end
      end

      state_nxt.drive_one_r = fan_ramp_pkg::floor_duty(auto_mode_in[0],
                                 below_thresh_in[0], floor_select_ch1,
                                 min_duty_one_in, calc_duty_one_in);
      state_nxt.drive_two_r = fan_ramp_pkg::floor_duty(auto_mode_in[1],
                                 below_thresh_in[1], floor_select_ch2,
                                 min_duty_two_in, calc_duty_two_in);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r             <= '0;
         state_r.floor_cfg_r <= `FLOOR_CFG_RST;
         state_r.ramp_cfg_r  <= `RAMP_CFG_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Ramp on channel three only; one and two follow at once
   fan_ramp_slew u_slew (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .ramp_en_in   (ramp_enable_ch3),
      .rate_in      (ramp_rate_ch3),
      .slot_tick_in (slot_tick_in),
      .target_in    (target_three),
      .duty_out     (fan_drive_three_out)
   );

   assign rd_data_out       = state_r.rd_data_r;
   assign fan_drive_one_out = state_r.drive_one_r;
   assign fan_drive_two_out = state_r.drive_two_r;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   logic [8:0] step_now;
   assign step_now = {1'b0, fan_ramp_pkg::step_size(ramp_rate_ch3)};

   sequence s_locked_floor_write;
      state_r.lock_r && wr_en_in && addr_in == `FLOOR_CFG_ADDR;
   endsequence

   sequence s_floor_stays;
      $stable(state_r.floor_cfg_r) ##1 $stable(state_r.floor_cfg_r);
   endsequence

   sequence s_locked_ramp_write;
      state_r.lock_r && wr_en_in && addr_in == `RAMP_CFG_ADDR;
   endsequence

   sequence s_ramp_stays;
      $stable(state_r.ramp_cfg_r);
   endsequence

   a_floor_ch1_out: assert property (
      auto_mode_in[0] && below_thresh_in[0]
      |=> fan_drive_one_out == ($past(floor_select_ch1) ?
                                $past(min_duty_one_in) : 8'h00))
      else $error("Channel one floor duty wrong");

   a_floor_ch2_out: assert property (
      auto_mode_in[1] && below_thresh_in[1] && !floor_select_ch2
      |=> fan_drive_two_out == 8'h00)
      else $error("Channel two not off below threshold");

   a_floor_ch2_min: assert property (
      auto_mode_in[1] && below_thresh_in[1] && floor_select_ch2
      |=> fan_drive_two_out == $past(min_duty_two_in))
      else $error("Channel two not at minimum duty");

   a_floor_ch3_min: assert property (
      !ramp_enable_ch3 && auto_mode_in[2] && below_thresh_in[2]
      && floor_select_ch3
      |=> fan_drive_three_out == $past(min_duty_three_in))
      else $error("Channel three not at minimum duty");

   a_floor_ch3_off: assert property (
      !ramp_enable_ch3 && auto_mode_in[2] && below_thresh_in[2]
      && !floor_select_ch3
      |=> fan_drive_three_out == 8'h00)
      else $error("Channel three not off below threshold");

   a_lock_blocks_write: assert property (
      s_locked_floor_write |=> s_floor_stays)
      else $error("Floor register changed while locked");

   a_lock_blocks_ramp: assert property (
      s_locked_ramp_write |=> s_ramp_stays)
      else $error("Ramp register changed while locked");

   a_ramp_reset_zero: assert property (
      $rose(rst_n_in) |-> state_r.ramp_cfg_r == 8'h00)
      else $error("Ramp register not zero after reset");

   a_ramp_step_up: assert property (
      ramp_enable_ch3 && slot_tick_in &&
      {1'b0, target_three} > {1'b0, fan_drive_three_out} + step_now
      |=> {1'b0, fan_drive_three_out} ==
          {1'b0, $past(fan_drive_three_out)} + $past(step_now))
      else $error("Ramp step up wrong size");

   a_ramp_step_down: assert property (
      ramp_enable_ch3 && slot_tick_in &&
      {1'b0, fan_drive_three_out} > {1'b0, target_three} + step_now
      |=> {1'b0, fan_drive_three_out} ==
          {1'b0, $past(fan_drive_three_out)} - $past(step_now))
      else $error("Ramp step down wrong size");

   a_ramp_lands_target: assert property (
      ramp_enable_ch3 && slot_tick_in &&
      {1'b0, target_three} <= {1'b0, fan_drive_three_out} + step_now &&
      {1'b0, fan_drive_three_out} <= {1'b0, target_three} + step_now
      |=> fan_drive_three_out == $past(target_three))
      else $error("Ramp did not land on target");

   a_ramp_code_max: assert property (
      ramp_enable_ch3 && slot_tick_in && ramp_rate_ch3 == 3'h7 &&
      fan_drive_three_out == 8'h00 && target_three == 8'hff
      |=> fan_drive_three_out == 8'h30)
      else $error("Fastest ramp code step not 48");

   a_ramp_hold_slot: assert property (
      ramp_enable_ch3 && !slot_tick_in && $stable(ramp_enable_ch3)
      |=> fan_drive_three_out == $past(fan_drive_three_out))
      else $error("Channel three moved between slots");

   a_no_ramp_direct: assert property (
      !ramp_enable_ch3 |=> fan_drive_three_out == $past(target_three))
      else $error("Channel three not applied at once");

endmodule : fan_pwm_floor_ramp

// *** rtl/fan_ramp_cfg.svh ***
// Constants for the fan floor-select and ramp-rate block.
// Assumes an 8-bit register port and 8-bit duty values (0x00..0xff).
`ifndef FAN_RAMP_CFG_SVH
`define FAN_RAMP_CFG_SVH

// Register offsets
`define FLOOR_CFG_ADDR   8'h70
`define RAMP_CFG_ADDR    8'h63
`define LOCK_CFG_ADDR    8'h71

// Reset values
`define FLOOR_CFG_RST    8'h00
`define RAMP_CFG_RST     8'h00

// Floor-select register fields
`define FLOOR_CH1_BIT    5
`define FLOOR_CH2_BIT    6
`define FLOOR_CH3_BIT    7

// Ramp register fields
`define RATE_CH3_LSB     0
`define RATE_CH3_MSB     2
`define RAMP_EN_CH3_BIT  3

// Lock register field
`define LOCK_BIT         0

// Duty step per time slot for each ramp code
`define STEP_CODE_0      8'h01
`define STEP_CODE_1      8'h02
`define STEP_CODE_2      8'h03
`define STEP_CODE_3      8'h05
`define STEP_CODE_4      8'h08
`define STEP_CODE_5      8'h0c
`define STEP_CODE_6      8'h18
`define STEP_CODE_7      8'h30

`endif

// *** rtl/fan_ramp_pkg.sv ***
// Types and helper functions for the fan floor-select and ramp block.
// Assumes fan_ramp_cfg.svh is on the include path.
`include "fan_ramp_cfg.svh"

package fan_ramp_pkg;

   typedef logic [7:0] duty_t;

   // State of the top-level block
   typedef struct packed {
      logic [7:0] floor_cfg_r;
      logic [7:0] ramp_cfg_r;
      logic       lock_r;
      logic [7:0] rd_data_r;
      duty_t      drive_one_r;
      duty_t      drive_two_r;
   } ctrl_s;

   // State of the slew stage
   typedef struct packed {
      duty_t duty_r;
   } slew_s;

   // Duty step taken per slot for a ramp code
   function automatic duty_t step_size(input logic [2:0] code);
      duty_t s;
      s = `STEP_CODE_0;
      case (code)
         3'h0: s = `STEP_CODE_0;
         3'h1: s = `STEP_CODE_1;
         3'h2: s = `STEP_CODE_2;
         3'h3: s = `STEP_CODE_3;
         3'h4: s = `STEP_CODE_4;
         3'h5: s = `STEP_CODE_5;
         3'h6: s = `STEP_CODE_6;
         default: s = `STEP_CODE_7;
      endcase
      return s;
   endfunction : step_size

   // Duty in automatic mode: below threshold the floor bit picks 0 or min
   function automatic duty_t floor_duty(input logic  auto_mode,
                                        input logic  below,
                                        input logic  hold_min,
                                        input duty_t min_duty,
                                        input duty_t calc_duty);
      duty_t d;
      d = calc_duty;
      if (auto_mode && below) begin
         d = hold_min ? min_duty : 8'h00;
      end
      return d;
   endfunction : floor_duty

endpackage : fan_ramp_pkg

// *** rtl/fan_ramp_slew.sv ***
// Slew stage for the third fan drive: steps toward a target each slot.
// Assumes slot_tick_in is a one-cycle pulse marking each ramp time slot.
`timescale 1ns/1ps
`include "fan_ramp_cfg.svh"

module fan_ramp_slew (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Control
   input  wire logic       ramp_en_in,
   input  wire logic [2:0] rate_in,
   input  wire logic       slot_tick_in,
   input  wire logic [7:0] target_in,
   // Result
   output logic      [7:0] duty_out
);

   fan_ramp_pkg::slew_s state_r;
   fan_ramp_pkg::slew_s state_nxt;

   always_comb begin
      logic [8:0] cur;
      logic [8:0] tgt;
      logic [8:0] inc;
      cur = {1'b0, state_r.duty_r};
      tgt = {1'b0, target_in};
      inc = {1'b0, fan_ramp_pkg::step_size(rate_in)};
      state_nxt = state_r;
      if (!ramp_en_in) begin
         state_nxt.duty_r = target_in;
      end else if (slot_tick_in) begin
         // Last step lands exactly on the target, never overshoots
         if (tgt > cur) begin
            state_nxt.duty_r = (tgt - cur > inc) ?
                               8'(cur + inc) : target_in;
         end else if (tgt < cur) begin
            state_nxt.duty_r = (cur - tgt > inc) ?
                               8'(cur - inc) : target_in;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign duty_out = state_r.duty_r;

endmodule : fan_ramp_slew

// *** verif/fan_load_model.sv ***
// Load model for the three fan drive outputs.
// Assumes duty values arrive as 8-bit levels, synchronous to clk_in.
`timescale 1ns/1ps

module fan_load_model (
   // Clock
   input  wire logic       clk_in,
   // Duty seen by each fan
   input  wire logic [7:0] duty_one_in,
   input  wire logic [7:0] duty_two_in,
   input  wire logic [7:0] duty_three_in,
   // Fan spinning flags
   output logic      [2:0] spin_out
);
   // A fan at 0% duty stops; any other duty keeps it turning
   always_ff @(posedge clk_in) begin
      spin_out <= {duty_three_in != 8'h00, duty_two_in != 8'h00,
                   duty_one_in != 8'h00};
   end
endmodule : fan_load_model

// *** verif/fan_pwm_floor_ramp_tb.sv ***
// Self-checking bench for the fan floor-select and ramp block.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps

module fan_pwm_floor_ramp_tb;
   logic       clk_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wr_data_in = 8'h00;
   logic       wr_en_in = 1'b0;
   logic       rd_en_in = 1'b0;
   logic [2:0] auto_mode_in = 3'h0;
   logic [2:0] below_in = 3'h0;
   logic       tick_in = 1'b0;
   logic [7:0] calc3 = 8'h33;
   logic [7:0] rd_data_out, d1, d2, d3;
   logic [2:0] spin;
   int         err_total = 0;
   int         n_tests = 0;
   int         cyc = 0;

   fan_pwm_floor_ramp u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
      .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
      .auto_mode_in(auto_mode_in), .below_thresh_in(below_in),
      .slot_tick_in(tick_in), .min_duty_one_in(8'h40),
      .min_duty_two_in(8'h80), .min_duty_three_in(8'hc0),
      .calc_duty_one_in(8'h11), .calc_duty_two_in(8'h22),
      .calc_duty_three_in(calc3), .fan_drive_one_out(d1),
      .fan_drive_two_out(d2), .fan_drive_three_out(d3));

   fan_load_model u_fans (.clk_in(clk_in), .duty_one_in(d1),
      .duty_two_in(d2), .duty_three_in(d3), .spin_out(spin));

   initial begin
      forever #12.5 clk_in = ~clk_in;
   end

   task check(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_en_in   <= 1'b1;
      @(posedge clk_in);
      wr_en_in   <= 1'b0;
   endtask : wr

   task rd_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1;
      check("read data", rd_data_out, exp);
   endtask : rd_check

   task wait_n(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : wait_n

   // One slot tick, then channel three is judged right after it lands
   task tick_step(input string what, input logic [7:0] exp);
      @(posedge clk_in);
      tick_in <= 1'b1;
      @(posedge clk_in);
      tick_in <= 1'b0;
      #1;
      check(what, d3, exp);
   endtask : tick_step

   task reset_test;
      rd_check(8'h63, 8'h00);
      rd_check(8'h70, 8'h00);
      rd_check(8'h71, 8'h00);
      wr(8'h55, 8'hff);
      rd_check(8'h55, 8'h00);
      wr(8'h63, 8'h0b);
      rd_check(8'h63, 8'h0b);
      $display("reset and register test done");
   endtask : reset_test

   // Both floor settings, then above threshold for the plain path
   task floor_test;
      wr(8'h63, 8'h00);
      auto_mode_in <= 3'h7;
      below_in     <= 3'h7;
      for (int f = 0; f < 2; f++) begin
         wr(8'h70, f ? 8'he0 : 8'h00);
         wait_n(2);
         check("drive one", d1, f ? 8'h40 : 8'h00);
         check("drive two", d2, f ? 8'h80 : 8'h00);
         check("drive three", d3, f ? 8'hc0 : 8'h00);
         wait_n(1);
         check("fans spin", {5'h00, spin}, f ? 8'h07 : 8'h00);
      end
      @(posedge clk_in);
      below_in <= 3'h0;
      wait_n(2);
      check("drive one", d1, 8'h11);
      check("drive two", d2, 8'h22);
      check("drive three", d3, 8'h33);
      // Manual mode ignores the floor bits even below threshold
      @(posedge clk_in);
      auto_mode_in <= 3'h0;
      below_in     <= 3'h7;
      wait_n(2);
      check("drive one manual", d1, 8'h11);
      check("drive two manual", d2, 8'h22);
      check("drive three manual", d3, 8'h33);
      $display("floor select test done");
   endtask : floor_test

   // Each ramp code: jump down with ramp off, then one slot upward
   task ramp_test;
      logic [7:0] steps [8];
      steps = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
      for (int c = 0; c < 8; c++) begin
         wr(8'h63, 8'h00);
         calc3 <= 8'h00;
         wait_n(2);
         check("drive three jump", d3, 8'h00);
         wr(8'h63, 8'h08 | 8'(c));
         calc3 <= 8'hff;
         wait_n(3);
         check("drive three held", d3, 8'h00);
         tick_step("drive three step", steps[c]);
      end
      $display("ramp rate test done");
   endtask : ramp_test

   task lock_test;
      wr(8'h63, 8'h0d);
      wr(8'h70, 8'ha0);
      wr(8'h71, 8'h01);
      wr(8'h70, 8'h40);
      wr(8'h63, 8'h02);
      wr(8'h71, 8'h00);
      rd_check(8'h70, 8'ha0);
      rd_check(8'h63, 8'h0d);
      rd_check(8'h71, 8'h01);
      $display("lock test done");
   endtask : lock_test

   // Fastest code: climb onto full duty, then fall and land on zero
   task slew_test;
      logic [7:0] up [5];
      logic [7:0] down [6];
      up   = '{8'h60, 8'h90, 8'hc0, 8'hf0, 8'hff};
      down = '{8'hcf, 8'h9f, 8'h6f, 8'h3f, 8'h0f, 8'h00};
      for (int i = 0; i < 5; i++) begin
         tick_step("drive three climb", up[i]);
      end
      @(posedge clk_in);
      calc3 <= 8'h00;
      for (int i = 0; i < 6; i++) begin
         tick_step("drive three fall", down[i]);
      end
      $display("slew test done");
   endtask : slew_test

   // Mid-run reset clears the lock and the ramp register
   task reset_again_test;
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd_check(8'h63, 8'h00);
      rd_check(8'h71, 8'h00);
      wr(8'h70, 8'h20);
      rd_check(8'h70, 8'h20);
      $display("mid-run reset test done");
   endtask : reset_again_test

   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   // Whole run needs well under a thousand cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      reset_test();
      floor_test();
      ramp_test();
      slew_test();
      lock_test();
      reset_again_test();
      give_verdict();
   end
endmodule : fan_pwm_floor_ramp_tb
